// ==== rtl/pll_ctrl_pkg.sv ====
// Constants shared by the loop divider and lock control logic.
// Assumes a single reference-rate system clock and no register bus.
package pll_ctrl_pkg;

	// Divider field widths
	localparam int NDIV_W = 8;
	localparam int MDIV_W = 15;
	localparam int PDIV_W = 5;

	// Lock detection
	localparam int LOCK_GOOD_RUN   = 8;
	localparam int LOCK_CNT_W      = 4;
	localparam int PHASE_W         = 16;
	localparam logic [15:0] PHASE_LIMIT_RST = 16'h0004;

	// Settle wait software uses when lock cannot be trusted
	localparam int CLK_MHZ         = 125;
	localparam int SETTLE_WAIT_MS  = 6;
	localparam int SETTLE_CYCLES   = SETTLE_WAIT_MS * 1000 * CLK_MHZ;

	// Reset values
	localparam logic [7:0]  NCODE_RST = 8'h00;
	localparam logic [14:0] MCODE_RST = 15'h0000;
	localparam logic [4:0]  PCODE_RST = 5'h00;

endpackage

// ==== rtl/pll_div_counter.sv ====
// Programmable clock-enable divider with encoded ratio.
// Assumes its enable input and clear arrive synchronous to clk_sys.
`timescale 1ns/10ps
module pll_div_counter #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         reset_n,
	input  wire logic         divClear,
	// Input events and encoded ratio
	input  wire logic         inTick,
	input  wire logic [W-1:0] ratioCode,
	// Divided event
	output logic              outTick
);

	logic [W-1:0] count_reg;

	// Encoded ratio: code c divides by c+1, all ones is the top ratio
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= '0;
			outTick   <= 1'b0;
		end else if (divClear) begin
			count_reg <= '0;
			outTick   <= 1'b0;
		end else begin
			outTick <= 1'b0;
			if (inTick) begin
				if (count_reg >= ratioCode) begin
					count_reg <= '0;
					outTick   <= 1'b1;
				end else begin
					count_reg <= count_reg + 1'b1;
				end
			end
		end
	end

endmodule

// ==== rtl/pll_divider_lock_control.sv ====
// Loop dividers and lock detector of the system phase-locked loop.
// Assumes oscillator and reference edges arrive as clk_sys-synchronous
// ticks and that the analog error path lies outside.
// Functional notes
// - Pre-divider divides reference by 1 to 256
// - Feedback divides by M or 2M
// - Post-divider passes through or divides by 2P
// - All ratios loaded as encoded settings
// - Feedback and reference compared for phase error
// - Lock rises after more than seven good periods
// - One bad measurement clears count and lock
// - Power-down holds dividers reset, lock low
// - Resume with new values, relock before flag
`timescale 1ns/10ps
module pll_divider_lock_control #(
	parameter int NW = pll_ctrl_pkg::NDIV_W,
	parameter int MW = pll_ctrl_pkg::MDIV_W,
	parameter int PW = pll_ctrl_pkg::PDIV_W
) (
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          reset_n,
	// Control
	input  wire logic          loopPowerdownBit,
	input  wire logic [NW-1:0] preDivCode,
	input  wire logic [MW-1:0] fbDivCode,
	input  wire logic          fbDoubleSel,
	input  wire logic          postDivBypass,
	input  wire logic [PW-1:0] postDivCode,
	input  wire logic [15:0]   lockCriterion,
	// Clock event ticks
	input  wire logic          refTick,
	input  wire logic          oscTick,
	// Results
	output logic               pfdRefTick,
	output logic               pfdFbTick,
	output logic               pfdUp,
	output logic               pfdDown,
	output logic               outTick,
	output logic               lockFlag
);

	logic          divClear;
	logic          refDiv;
	logic          fbPre;
	logic          fbHalf_reg;
	logic          fbDiv;
	logic          postDiv;
	logic          postHalf_reg;
	logic [15:0]   phase_reg;
	logic          waitFb_reg;
	logic [pll_ctrl_pkg::LOCK_CNT_W-1:0] good_reg;

	assign divClear = loopPowerdownBit;

	AST_PD_CLEAR: assert property (@(posedge clk_sys)
		disable iff (!reset_n)
		divClear |=> good_reg == '0 && !outTick && !pfdUp)
		else $error("dividers not held in power-down");

	// Pre-divider, code n gives ratio n+1
	pll_div_counter #(.W(NW)) uPre (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.divClear (divClear),
		.inTick   (refTick),
		.ratioCode(preDivCode),
		.outTick  (refDiv)
	);

	AST_PRE: assert property (@(posedge clk_sys)
		disable iff (!reset_n)
		refDiv && preDivCode == '0 && !divClear && $stable(preDivCode)
		&& refTick |=> refDiv)
		else $error("pre-divider ratio one wrong");

	// Feedback divider by M
	pll_div_counter #(.W(MW)) uFb (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.divClear (divClear),
		.inTick   (oscTick),
		.ratioCode(fbDivCode),
		.outTick  (fbPre)
	);

	// Post-divider by P before the final halving
	pll_div_counter #(.W(PW)) uPost (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.divClear (divClear),
		.inTick   (oscTick),
		.ratioCode(postDivCode),
		.outTick  (postDiv)
	);

	// Optional extra halving in the feedback path
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fbHalf_reg <= 1'b0;
		end else if (divClear) begin
			fbHalf_reg <= 1'b0;
		end else if (fbPre && fbDoubleSel) begin
			fbHalf_reg <= ~fbHalf_reg;
		end
	end
	assign fbDiv = fbPre && (!fbDoubleSel || fbHalf_reg);

	AST_FB_DOUBLE: assert property (@(posedge clk_sys)
		disable iff (!reset_n)
		!divClear && fbDoubleSel && fbPre && !fbHalf_reg
		|=> fbHalf_reg && !pfdFbTick)
		else $error("feedback halving skipped");

	// Post-divider halving and output select
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			postHalf_reg <= 1'b0;
			outTick      <= 1'b0;
		end else if (divClear) begin
			postHalf_reg <= 1'b0;
			outTick      <= 1'b0;
		end else begin
			if (postDiv) begin
				postHalf_reg <= ~postHalf_reg;
			end
			if (postDivBypass) begin
				outTick <= oscTick;
			end else begin
				outTick <= postDiv && postHalf_reg;
			end
		end
	end

	AST_BYPASS: assert property (@(posedge clk_sys)
		disable iff (!reset_n)
		!divClear && postDivBypass |=> outTick == $past(oscTick))
		else $error("post bypass wrong");

	// Phase-frequency detector direction pulses
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pfdRefTick <= 1'b0;
			pfdFbTick  <= 1'b0;
			pfdUp      <= 1'b0;
			pfdDown    <= 1'b0;
		end else if (divClear) begin
			pfdRefTick <= 1'b0;
			pfdFbTick  <= 1'b0;
			pfdUp      <= 1'b0;
			pfdDown    <= 1'b0;
		end else begin
			pfdRefTick <= refDiv;
			pfdFbTick  <= fbDiv;
			pfdUp      <= refDiv && !fbDiv;
			pfdDown    <= fbDiv && !refDiv;
		end
	end

	AST_PFD: assert property (@(posedge clk_sys)
		disable iff (!reset_n)
		!divClear && refDiv && !fbDiv |=> pfdUp && !pfdDown)
		else $error("detector direction wrong");

	// Phase error from reference edge to next feedback edge
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			phase_reg  <= 16'h0000;
			waitFb_reg <= 1'b0;
		end else if (divClear) begin
			phase_reg  <= 16'h0000;
			waitFb_reg <= 1'b0;
		end else if (refDiv) begin
			phase_reg  <= 16'h0000;
			waitFb_reg <= !fbDiv;
		end else if (waitFb_reg) begin
			if (fbDiv) begin
				waitFb_reg <= 1'b0;
			end else if (phase_reg != 16'hFFFF) begin
				phase_reg <= phase_reg + 16'h0001;
			end
		end
	end

	// Judgement at each reference period
	logic measBad;
	assign measBad = refDiv && (waitFb_reg || phase_reg > lockCriterion);

	// Consecutive good counter
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			good_reg <= '0;
		end else if (divClear) begin
			good_reg <= '0;
		end else if (measBad) begin
			good_reg <= '0;
		end else if (refDiv &&
			good_reg != pll_ctrl_pkg::LOCK_CNT_W'(pll_ctrl_pkg::LOCK_GOOD_RUN)) begin
			good_reg <= good_reg + 1'b1;
		end
	end

	AST_SAT: assert property (@(posedge clk_sys)
		disable iff (!reset_n)
		good_reg <= pll_ctrl_pkg::LOCK_CNT_W'(pll_ctrl_pkg::LOCK_GOOD_RUN))
		else $error("good counter overran");

	// Lock flag
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			lockFlag <= 1'b0;
		end else if (divClear || measBad) begin
			lockFlag <= 1'b0;
		end else begin
			lockFlag <= good_reg ==
				pll_ctrl_pkg::LOCK_CNT_W'(pll_ctrl_pkg::LOCK_GOOD_RUN);
		end
	end

	AST_PD_NO_LOCK: assert property (@(posedge clk_sys)
		disable iff (!reset_n)
		loopPowerdownBit |=> !lockFlag)
		else $error("lock high during power-down");
	AST_BAD_DROPS: assert property (@(posedge clk_sys)
		disable iff (!reset_n)
		measBad |=> !lockFlag && good_reg == '0)
		else $error("bad phase did not drop lock");
	AST_RISE_NEEDS_RUN: assert property (@(posedge clk_sys)
		disable iff (!reset_n)
		$rose(lockFlag) |-> $past(good_reg) ==
			pll_ctrl_pkg::LOCK_CNT_W'(pll_ctrl_pkg::LOCK_GOOD_RUN))
		else $error("lock rose without good run");

endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the loop divider and lock control block.
// Assumes ticks are one-cycle pulses and inputs change at falling edges.
`timescale 1ns/10ps
module testbench;
	logic        clk_sys          = 1'b0;
	logic        reset_n          = 1'b0;
	logic        loopPowerdownBit = 1'b1;
	logic [7:0]  preDivCode       = 8'h00;
	logic [14:0] fbDivCode        = 15'h0000;
	logic        fbDoubleSel      = 1'b0;
	logic        postDivBypass    = 1'b1;
	logic [4:0]  postDivCode      = 5'h00;
	logic [15:0] lockCriterion    = 16'h0004;
	logic        refTick          = 1'b0;
	logic        oscTick          = 1'b0;
	logic        pfdRefTick, pfdFbTick, pfdUp, pfdDown, outTick, lockFlag;
	logic [15:0] cRef, cFb, cOut, cUp, cDn;
	int          errors           = 0;
	int          checked          = 0;

	pll_divider_lock_control pll_divider_lock_control_inst (
		.clk_sys(clk_sys), .reset_n(reset_n),
		.loopPowerdownBit(loopPowerdownBit), .preDivCode(preDivCode),
		.fbDivCode(fbDivCode), .fbDoubleSel(fbDoubleSel),
		.postDivBypass(postDivBypass), .postDivCode(postDivCode),
		.lockCriterion(lockCriterion), .refTick(refTick),
		.oscTick(oscTick), .pfdRefTick(pfdRefTick), .pfdFbTick(pfdFbTick),
		.pfdUp(pfdUp), .pfdDown(pfdDown), .outTick(outTick),
		.lockFlag(lockFlag));

	always #4 clk_sys = ~clk_sys;

	task automatic chk_cnt(input string n, input logic [15:0] e, s);
		checked++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %0d seen %0d", n, e, s);
		end
	endtask

	task automatic chk_bit(input string n, input logic e, s);
		checked++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %b seen %b", n, e, s);
		end
	endtask

	// Runs n cycles of ticks, counting divided events at every falling edge
	task automatic cyc(input int n, input int rp, input int op, input int of);
		for (int i = 0; i <= n; i++) begin
			@(negedge clk_sys);
			cRef += (pfdRefTick === 1'b1);
			cFb += (pfdFbTick === 1'b1);
			cOut += (outTick === 1'b1);
			cUp += (pfdUp === 1'b1);
			cDn += (pfdDown === 1'b1);
			refTick = (i < n) && (rp > 0) && (i % rp == 0);
			oscTick = (i < n) && (op > 0) && (i % op == of);
		end
	endtask

	// Clean start through power-down with new codes
	task automatic start(input logic [7:0] n, input logic [14:0] m,
			input logic d, input logic b, input logic [4:0] p);
		@(negedge clk_sys);
		loopPowerdownBit = 1'b1;
		repeat (2) @(negedge clk_sys);
		{preDivCode, fbDivCode, fbDoubleSel} = {n, m, d};
		{postDivBypass, postDivCode} = {b, p};
		loopPowerdownBit = 1'b0;
		@(negedge clk_sys);
		{cRef, cFb, cOut, cUp, cDn} = '0;
	endtask

	task automatic test_dividers;
		start(8'h02, 15'h0003, 1'b0, 1'b1, 5'h00);
		cyc(30, 1, 1, 0);
		cyc(4, 0, 0, 0);
		chk_cnt("preDiv", 16'h000A, cRef);
		chk_cnt("fbDiv", 16'h0007, cFb);
		chk_cnt("bypass", 16'h001E, cOut);
		chk_cnt("pfdUp", 16'h0008, cUp);
		chk_cnt("pfdDown", 16'h0005, cDn);
		start(8'hFF, 15'h0003, 1'b1, 1'b0, 5'h01);
		cyc(256, 1, 1, 0);
		cyc(4, 0, 0, 0);
		chk_cnt("preDiv256", 16'h0001, cRef);
		chk_cnt("fbDiv2M", 16'h0020, cFb);
		chk_cnt("postDiv2P", 16'h0040, cOut);
		start(8'h00, 15'h0000, 1'b0, 1'b0, 5'h00);
		cyc(16, 1, 1, 0);
		cyc(4, 0, 0, 0);
		chk_cnt("preDiv1", 16'h0010, cRef);
		chk_cnt("fbDivM1", 16'h0010, cFb);
		chk_cnt("postDiv2", 16'h0008, cOut);
		$display("test_dividers done");
	endtask

	task automatic test_lock;
		start(8'h00, 15'h0000, 1'b0, 1'b1, 5'h00);
		cyc(48, 8, 8, 2);
		chk_bit("lockEarly", 1'b0, lockFlag);
		cyc(80, 8, 8, 2);
		chk_bit("lockSet", 1'b1, lockFlag);
		cyc(160, 8, 8, 2);
		chk_bit("lockHold", 1'b1, lockFlag);
		cyc(24, 8, 8, 6);
		chk_bit("lockBadPhase", 1'b0, lockFlag);
		cyc(128, 8, 8, 2);
		cyc(24, 8, 0, 0);
		chk_bit("lockNoFb", 1'b0, lockFlag);
		$display("test_lock done");
	endtask

	task automatic test_powerdown;
		start(8'h00, 15'h0000, 1'b0, 1'b1, 5'h00);
		cyc(128, 8, 8, 2);
		chk_bit("lockBeforePd", 1'b1, lockFlag);
		loopPowerdownBit = 1'b1;
		fbDivCode = 15'h0001;
		{cRef, cFb, cOut} = '0;
		cyc(32, 1, 1, 0);
		chk_bit("lockInPd", 1'b0, lockFlag);
		chk_cnt("ticksInPd", 16'h0000, cRef + cFb + cOut);
		loopPowerdownBit = 1'b0;
		{cRef, cFb, cOut} = '0;
		cyc(24, 8, 4, 0);
		chk_bit("lockAfterPd", 1'b0, lockFlag);
		cyc(160, 8, 4, 0);
		chk_cnt("newFbRatio", 16'h0017, cFb);
		chk_bit("relock", 1'b1, lockFlag);
		$display("test_powerdown done");
	endtask

	task automatic finish_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(negedge clk_sys);
		reset_n = 1'b1;
		@(negedge clk_sys);
		chk_bit("lockReset", 1'b0, lockFlag);
		test_dividers();
		test_lock();
		test_powerdown();
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		finish_test();
	end
endmodule
